/* pmsm_regs.svh */
// Purpose: Timing constants and reset values of the power-mode state machine.
// Assumes: A 125 MHz system clock and a 32768 Hz slow time base.
// Notes: Times are kept in their own unit; tick counts are derived here.
`ifndef PMSM_REGS_SVH
`define PMSM_REGS_SVH

`define PMSM_CLK_HZ 125000000
`define PMSM_SLOW_HZ 32768
// Converts microseconds to slow ticks; sized so large products do not wrap.
`define PMSM_TICKS(us) (((us) * 64'd32768) / 64'd1000000)

`define PMSM_DBNC_SHORT_US 31250
`define PMSM_DBNC_MID_US 125000
`define PMSM_DBNC_LONG_US 750000
`define PMSM_HOLD_WAKE_US 1000000
`define PMSM_HOLD_OFF_US 4000000
`define PMSM_STBY_DLY_UNIT_TICKS 8'h20

`define PMSM_DBNC_SEL_MID 2'h2
`define PMSM_DBNC_SEL_LONG 2'h3
`define PMSM_BUTTON_BIT 0
`define PMSM_POWER_ON_BIT 1
`define PMSM_DB_RESET 2'h1
`define PMSM_STBY_POL_RESET 1'h0

`endif

/* pmsm_pkg.sv */
// Purpose: Types shared by the power-mode state machine and its users.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Constants live in pmsm_regs.svh.
package pmsm_pkg;

    typedef enum logic [2:0] {
        ST_REGS_OFF,
        ST_RUN,
        ST_STANDBY,
        ST_SLEEP,
        ST_CORE_SHUT,
        ST_TRANSPORT
    } pmsm_state_e;

    typedef struct packed {
        logic up_req;
        logic down_req;
        logic regs_on;
        logic rtc_supply_en;
    } pmsm_seq_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } pmsm_btn_int_s;

endpackage

/* pmsm_power_fsm.sv */
// Purpose: Power-mode state machine with push-button and power-on debounce.
// Assumes: Button, power-on and standby pins synchronous-safe via slow-tick synchronisers.
// Notes: Regulator timing itself is done by an outside sequencer.
`timescale 1ns/1ps
`include "pmsm_regs.svh"

// Function
// [RULE_01] Debounce turn-on with selectable 31.25/125/750 ms
// [RULE_02] Falling interrupt debounce selected, rising fixed short
// [RULE_03] Debounced button rise sets interrupt flag
// [RULE_04] Flag cleared by software or regulators-off
// [RULE_05] Six states in two groups
// [RULE_06] Off-to-on only via regulators-off into run
// [RULE_07] Turn-off moves any on state to regulators-off
// [RULE_08] Power up, then release host reset
// [RULE_09] Standby only from run, follows standby request
// [RULE_10] Standby request is pin XOR invert bit
// [RULE_11] Standby to run uses power-up order
// [RULE_12] Standby to sleep uses power-down order
// [RULE_13] Sleep entry from power-on pin, mode dependent
// [RULE_14] Sleep entry down, exit up sequence
// [RULE_15] Host reset released in run, standby, sleep
// [RULE_16] Host reset asserted in every off state
// [RULE_17] Long hold or charger attach wakes to off
// [RULE_18] Regulators-off and core-shutdown keep only backup supply
// [RULE_19] Turn-on is level high or falling edge
// [RULE_20] Turn-off event sources
// [RULE_21] No core-shutdown while charger attached
// [RULE_22] Three slow cycles standby synchronisation allowance
// [RULE_23] Two-flop sync, debounce counted in slow ticks
// [RULE_24] Reset to regulators-off, reset asserted, flags clear
module pmsm_power_fsm
    import pmsm_pkg::*;
#(
    parameter logic [11:0] TICK_DIV = 12'(`PMSM_CLK_HZ / `PMSM_SLOW_HZ),
    parameter logic [17:0] DBNC_LONG = 18'(`PMSM_TICKS(`PMSM_DBNC_LONG_US)),
    parameter logic [17:0] HOLD_WAKE = 18'(`PMSM_TICKS(`PMSM_HOLD_WAKE_US)),
    parameter logic [17:0] HOLD_OFF = 18'(`PMSM_TICKS(`PMSM_HOLD_OFF_US))
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Push button and power-on pin
    input wire logic push_button_input,
    input wire logic power_on_input,
    input wire logic power_on_edge_mode_cfg,
    input wire logic [1:0] button_debounce_sel,
    // Host processor pins and controls
    input wire logic standby_pin,
    input wire logic standby_polarity_invert,
    input wire logic [1:0] standby_holdoff_delay,
    input wire logic watchdog_reset_input,
    // System events and requests
    input wire logic thermal_shutdown,
    input wire logic charger_attached,
    input wire logic transport_request,
    input wire logic core_shutdown_request,
    input wire logic long_press_off_enable,
    input wire logic button_reset_enable,
    input wire logic sleep_keeps_any_reg,
    // Button interrupt flags
    input wire logic [1:0] button_int_clear,
    output pmsm_btn_int_s button_int,
    // Regulator sequencer handshake
    input wire logic seq_all_up,
    output pmsm_seq_s seq_cmd,
    // Host reset open-drain pin
    input wire logic host_reset_out_n_in,
    output logic host_reset_out_n_out,
    output logic host_reset_out_n_oe,
    // Status
    output pmsm_state_e power_state,
    output logic power_on_edge_mode
);

    localparam logic [17:0] DBNC_SHORT =
        18'(`PMSM_TICKS(`PMSM_DBNC_SHORT_US));
    localparam logic [17:0] DBNC_MID = 18'(`PMSM_TICKS(`PMSM_DBNC_MID_US));

    function automatic logic [17:0] dbnc_limit(input logic [1:0] sel);
        case (sel)
            `PMSM_DBNC_SEL_MID: dbnc_limit = DBNC_MID;
            `PMSM_DBNC_SEL_LONG: dbnc_limit = DBNC_LONG;
            default: dbnc_limit = DBNC_SHORT;
        endcase
    endfunction

    function automatic logic sys_on(input pmsm_state_e st);
        sys_on = (st == ST_RUN) || (st == ST_STANDBY) || (st == ST_SLEEP);
    endfunction

    logic [11:0] tick_cnt_ff;
    logic slow_tick;
    logic [1:0] sync1_ff, sync2_ff, db_ff, db_prev_ff;
    logic [17:0] dcnt_ff [2];
    logic [17:0] hold_ff [2];
    logic [1:0] db_rise, db_fall;
    logic [2:0] stby_sync_ff;
    logic [7:0] stby_dly_ff;
    logic stby_req, stby_go;
    logic edge_mode_ff, cfg_loaded_ff;
    logic chg_prev_ff, chg_evt;
    logic wake_arm_ff, start_done_ff, hr_rel_ff;
    logic btn_wake, btn_greset, pwr_long, wd_fault;
    logic turn_on, off_evt, sleep_go, sleep_exit;
    pmsm_state_e state_ff, nxt_state;
    pmsm_btn_int_s int_ff;
    pmsm_seq_s seq_ff;

    // Slow time base shared by debounce, hold and standby counters.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tick_cnt_ff <= 12'h000;
        else if (tick_cnt_ff == TICK_DIV - 12'h001)
            tick_cnt_ff <= 12'h000;
        else
            tick_cnt_ff <= tick_cnt_ff + 12'h001;
    end
    assign slow_tick = (tick_cnt_ff == 12'h000);

    // The edge-mode strap is caught once, after reset is released.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            edge_mode_ff <= 1'b0;
            cfg_loaded_ff <= 1'b0;
        end
        else if (!cfg_loaded_ff)
        begin
            edge_mode_ff <= power_on_edge_mode_cfg;
            cfg_loaded_ff <= 1'b1;
        end
    end

    // Channel 0 is the button, channel 1 the power-on pin.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_ff <= `PMSM_DB_RESET;
            sync2_ff <= `PMSM_DB_RESET;
            db_ff <= `PMSM_DB_RESET;
            dcnt_ff[0] <= 18'h00000;
            dcnt_ff[1] <= 18'h00000;
        end
        else if (slow_tick)
        begin
            sync1_ff <= {power_on_input, push_button_input}; // RULE_23
            sync2_ff <= sync1_ff; // RULE_23
            for (int i = 0; i < 2; i++)
            begin
                if (sync2_ff[i] == db_ff[i])
                    dcnt_ff[i] <= 18'h00000;
                else if (dcnt_ff[i] >= ((i == 1 || db_ff[i]) ?
                         dbnc_limit(button_debounce_sel) : DBNC_SHORT)
                         - 18'h00001) // RULE_01 RULE_02
                begin
                    db_ff[i] <= sync2_ff[i];
                    dcnt_ff[i] <= 18'h00000;
                end
                else
                    dcnt_ff[i] <= dcnt_ff[i] + 18'h00001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            db_prev_ff <= `PMSM_DB_RESET;
        else
            db_prev_ff <= db_ff;
    end
    assign db_rise = db_ff & ~db_prev_ff;
    assign db_fall = ~db_ff & db_prev_ff;

    // Hold timers restart on every state change, so a press still held is timed again in the new state.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!rst_n || db_ff[i] || nxt_state != state_ff)
                hold_ff[i] <= 18'h00000;
            else if (slow_tick && hold_ff[i] != 18'h3FFFF)
                hold_ff[i] <= hold_ff[i] + 18'h00001;
        end
    end
    assign btn_wake = hold_ff[`PMSM_BUTTON_BIT] > HOLD_WAKE;
    assign btn_greset = hold_ff[`PMSM_BUTTON_BIT] >= HOLD_OFF;
    assign pwr_long = hold_ff[`PMSM_POWER_ON_BIT] >= HOLD_OFF;

    // Three stages give the synchronisation allowance before hold-off.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stby_sync_ff <= {3{`PMSM_STBY_POL_RESET}};
        else if (slow_tick)
            stby_sync_ff <= {stby_sync_ff[1:0],
                             standby_pin ^ standby_polarity_invert}; // RULE_10
    end
    assign stby_req = stby_sync_ff[2]; // RULE_22

    always_ff @(posedge clk)
    begin
        if (!rst_n || !stby_req || state_ff != ST_RUN)
            stby_dly_ff <= 8'h00;
        else if (slow_tick && stby_dly_ff != 8'hFF)
            stby_dly_ff <= stby_dly_ff + 8'h01;
    end
    assign stby_go = stby_req && (stby_dly_ff >=
        8'(standby_holdoff_delay * `PMSM_STBY_DLY_UNIT_TICKS)); // RULE_22

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            chg_prev_ff <= 1'b0;
        else
            chg_prev_ff <= charger_attached;
    end
    assign chg_evt = charger_attached && !chg_prev_ff;

    // Watchdog is ignored until start-up has released the host reset.
    // The host holds the pin low while in reset, so gate on the release.
    assign wd_fault = !watchdog_reset_input && hr_rel_ff;
    assign turn_on = !thermal_shutdown && (edge_mode_ff ?
        db_fall[`PMSM_POWER_ON_BIT] : db_ff[`PMSM_POWER_ON_BIT]); // RULE_19
    assign off_evt = thermal_shutdown || transport_request || wd_fault ||
        (btn_greset && button_reset_enable) ||
        (edge_mode_ff ? (pwr_long && long_press_off_enable &&
            (!sleep_keeps_any_reg || state_ff == ST_SLEEP)) :
            (!db_ff[`PMSM_POWER_ON_BIT] && !sleep_keeps_any_reg)); // RULE_20
    assign sleep_go = sleep_keeps_any_reg && (edge_mode_ff ?
        (pwr_long && long_press_off_enable) :
        !db_ff[`PMSM_POWER_ON_BIT]); // RULE_13
    assign sleep_exit = edge_mode_ff ?
        (db_rise[`PMSM_POWER_ON_BIT] && wake_arm_ff) :
        db_ff[`PMSM_POWER_ON_BIT];

    // In edge mode, sleep is left for run only on a fresh press and release.
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_ff != ST_SLEEP)
            wake_arm_ff <= 1'b0;
        else if (db_fall[`PMSM_POWER_ON_BIT])
            wake_arm_ff <= 1'b1;
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff) // RULE_05
            ST_REGS_OFF:
            begin
                if (turn_on)
                    nxt_state = ST_RUN; // RULE_06
                else if (transport_request && !charger_attached)
                    nxt_state = ST_TRANSPORT;
                else if (!charger_attached && ((core_shutdown_request &&
                         db_ff[`PMSM_BUTTON_BIT]) ||
                         (btn_greset && button_reset_enable))) // RULE_21
                    nxt_state = ST_CORE_SHUT;
            end
            ST_RUN:
            begin
                if (off_evt)
                    nxt_state = ST_REGS_OFF; // RULE_07
                else if (sleep_go)
                    nxt_state = ST_SLEEP;
                else if (stby_go)
                    nxt_state = ST_STANDBY; // RULE_09
            end
            ST_STANDBY:
            begin
                if (off_evt)
                    nxt_state = ST_REGS_OFF; // RULE_07
                else if (sleep_go)
                    nxt_state = ST_SLEEP; // RULE_12
                else if (!stby_req)
                    nxt_state = ST_RUN; // RULE_09
            end
            ST_SLEEP:
            begin
                if (off_evt)
                    nxt_state = ST_REGS_OFF; // RULE_07
                else if (sleep_exit)
                    nxt_state = ST_RUN;
            end
            ST_CORE_SHUT, ST_TRANSPORT:
            begin
                if (btn_wake || chg_evt)
                    nxt_state = ST_REGS_OFF; // RULE_17
            end
            default:
                nxt_state = ST_REGS_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_ff <= ST_REGS_OFF; // RULE_24
        else
            state_ff <= nxt_state;
    end

    // Sequencer requests; up on any entry to run, down on any step down out of run, standby or sleep.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            seq_ff <= '{up_req: 1'b0, down_req: 1'b0, regs_on: 1'b0,
                        rtc_supply_en: 1'b1};
        else
        begin
            seq_ff.up_req <= nxt_state == ST_RUN &&
                             state_ff != ST_RUN; // RULE_08 RULE_11 RULE_14
            seq_ff.down_req <= nxt_state != state_ff && sys_on(state_ff) &&
                               nxt_state != ST_RUN; // RULE_12 RULE_14
            seq_ff.regs_on <= sys_on(nxt_state); // RULE_18
            seq_ff.rtc_supply_en <= nxt_state != ST_TRANSPORT; // RULE_18
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || !sys_on(state_ff))
            start_done_ff <= 1'b0;
        else if (state_ff == ST_RUN && seq_all_up)
            start_done_ff <= 1'b1; // RULE_08
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hr_rel_ff <= 1'b0; // RULE_24
        else
            // Next state is used so reset asserts with the off state.
            hr_rel_ff <= sys_on(nxt_state) && start_done_ff; // RULE_15 RULE_16
    end

    // A set in the same cycle as a clear is kept.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            int_ff <= '0; // RULE_24
        else
        begin
            int_ff.rise <= db_rise[`PMSM_BUTTON_BIT] || (int_ff.rise &&
                !button_int_clear[0] && state_ff != ST_REGS_OFF); // RULE_03
            int_ff.fall <= db_fall[`PMSM_BUTTON_BIT] || (int_ff.fall &&
                !button_int_clear[1] && state_ff != ST_REGS_OFF); // RULE_04
        end
    end

    assign button_int = int_ff;
    assign seq_cmd = seq_ff;
    assign host_reset_out_n_out = 1'b0;
    assign host_reset_out_n_oe = !hr_rel_ff;
    assign power_state = state_ff;
    assign power_on_edge_mode = edge_mode_ff;

    a_reset_off_group: assert property (@(posedge clk) disable iff (!rst_n)
        !sys_on(state_ff) |-> host_reset_out_n_oe) // RULE_16
        else $error("host reset released in an off state");
    a_reset_held_on: assert property (@(posedge clk) disable iff (!rst_n)
        start_done_ff && sys_on(nxt_state) |=> !host_reset_out_n_oe) // RULE_15
        else $error("host reset asserted in an on state");
    a_off_to_run: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == ST_REGS_OFF ##1 sys_on(state_ff)
        |-> state_ff == ST_RUN && $past(turn_on)) // RULE_06
        else $error("regulators-off left to a state other than run");
    a_standby_entry: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_ff == ST_STANDBY) |-> $past(state_ff) == ST_RUN
        && $past(stby_req)) // RULE_09
        else $error("standby entered from a state other than run");
    a_rise_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        db_rise[`PMSM_BUTTON_BIT] ##1
        (!button_int_clear[0] && state_ff != ST_REGS_OFF)
        |-> button_int.rise ##1 button_int.rise) // RULE_03
        else $error("button rise did not set the flag");
    a_off_clears_flag: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == ST_REGS_OFF && !db_rise[`PMSM_BUTTON_BIT]
        |=> !button_int.rise) // RULE_04
        else $error("button flag survived regulators-off");
    a_core_no_charger: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == ST_REGS_OFF && charger_attached
        |=> state_ff != ST_CORE_SHUT) // RULE_21
        else $error("core-shutdown entered with charger attached");
    a_off_backup_only: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff inside {ST_REGS_OFF, ST_CORE_SHUT}
        |-> !seq_cmd.regs_on && seq_cmd.rtc_supply_en) // RULE_18
        else $error("supplies wrong in regulators-off or core-shutdown");
    a_turn_off_now: assert property (@(posedge clk) disable iff (!rst_n)
        sys_on(state_ff) && off_evt |=> state_ff == ST_REGS_OFF) // RULE_07
        else $error("turn-off event did not reach regulators-off");
    a_run_powers_up: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_ff == ST_RUN) |-> seq_cmd.up_req
        ##1 !seq_cmd.up_req) // RULE_08
        else $error("run entered without one power-up request");

endmodule

/* pmsm_host_model.sv */
// Purpose: Behavioural host processor and regulator sequencer for the bench.
// Assumes: The host reset wire is already resolved with its pull-up.
// Notes: An unpowered host holds its pins low, as a real one would.
`timescale 1ns/1ps

module pmsm_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic standby_cmd,
    input wire logic wd_fire,
    // Device side
    input wire logic host_reset_n,
    input wire logic regs_on,
    output logic seq_all_up,
    output logic standby_pin,
    output logic watchdog_reset_input
);
    logic [2:0] ramp_ff;

    // Rails take several cycles to come up, so release is never instant.
    always_ff @(posedge clk)
    begin
        if (!rst_n || !regs_on)
            ramp_ff <= 3'h0;
        else if (ramp_ff != 3'h7)
            ramp_ff <= ramp_ff + 3'h1;
    end

    assign seq_all_up = (ramp_ff == 3'h7);
    assign standby_pin = host_reset_n & standby_cmd;
    assign watchdog_reset_input = host_reset_n & ~wd_fire;
endmodule

/* pmsm_power_fsm_tb.sv */
// Purpose: Self-checking bench for the power-mode state machine.
// Assumes: Short parameters; one slow tick every four clocks.
// Notes: Level-mode power-on pin first, then a reset with the strap high.
`timescale 1ns/1ps

module pmsm_power_fsm_tb;
    import pmsm_pkg::*;

    logic clk, rst_n, btn, pon, stby_cmd, stby_inv, wd_fire, therm;
    logic chg, transport_state_req, core_req, sleep_reg, all_up, stby_pin, wd_pin;
    logic [1:0] dbnc_sel, hold_dly, int_clr;
    pmsm_btn_int_s button_int;
    pmsm_seq_s seq_cmd;
    pmsm_state_e power_state;
    logic rst_out, rst_oe, edge_mode;
    logic edge_cfg, lp_en, btn_rst_en;
    wire logic host_rst_n = rst_oe ? rst_out : 1'b1;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    pmsm_power_fsm #(.TICK_DIV(12'h004), .DBNC_LONG(18'h00028),
        .HOLD_WAKE(18'h0003C), .HOLD_OFF(18'h00050)) u_pmsm_power_fsm (
        .clk(clk), .rst_n(rst_n), .push_button_input(btn),
        .power_on_input(pon), .power_on_edge_mode_cfg(edge_cfg),
        .button_debounce_sel(dbnc_sel), .standby_pin(stby_pin),
        .standby_polarity_invert(stby_inv),
        .standby_holdoff_delay(hold_dly), .watchdog_reset_input(wd_pin),
        .thermal_shutdown(therm), .charger_attached(chg),
        .transport_request(transport_state_req), .core_shutdown_request(core_req),
        .long_press_off_enable(lp_en), .button_reset_enable(btn_rst_en),
        .sleep_keeps_any_reg(sleep_reg), .button_int_clear(int_clr),
        .button_int(button_int), .seq_all_up(all_up), .seq_cmd(seq_cmd),
        .host_reset_out_n_in(host_rst_n), .host_reset_out_n_out(rst_out),
        .host_reset_out_n_oe(rst_oe), .power_state(power_state),
        .power_on_edge_mode(edge_mode));

    pmsm_host_model u_pmsm_host_model (
        .clk(clk), .rst_n(rst_n), .standby_cmd(stby_cmd),
        .wd_fire(wd_fire), .host_reset_n(host_rst_n),
        .regs_on(seq_cmd.regs_on), .seq_all_up(all_up),
        .standby_pin(stby_pin), .watchdog_reset_input(wd_pin));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Waits a bounded number of clocks for a state, then compares it.
    task automatic wait_st(input pmsm_state_e s, input int max_clk);
        for (n = 0; n < max_clk && power_state !== s; n++)
            @(negedge clk);
        check("power_state", 8'(power_state), 8'(s));
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        rst_n = 1'b0; btn = 1'b1; pon = 1'b0; stby_cmd = 1'b0;
        stby_inv = 1'b0; wd_fire = 1'b0; therm = 1'b0; chg = 1'b0;
        transport_state_req = 1'b0; core_req = 1'b0; sleep_reg = 1'b1;
        dbnc_sel = 2'h0; hold_dly = 2'h0; int_clr = 2'h0;
        edge_cfg = 1'b0; lp_en = 1'b0; btn_rst_en = 1'b0;
        repeat (6) @(negedge clk);
        check("state", 8'(power_state), 8'(ST_REGS_OFF));
        check("reset_oe", 8'(rst_oe), 8'h01);
        check("int", 8'(button_int), 8'h00);
        check("seq", 8'(seq_cmd), 8'h01);
        rst_n = 1'b1;
        @(negedge clk);
        check("edge_mode", 8'(edge_mode), 8'h00);
        // A watchdog low from the unpowered host must not block turn-on.
        pon = 1'b1;
        wait_st(ST_RUN, 4400);
        check("up_req", 8'(seq_cmd.up_req), 8'h01);
        check("regs_on", 8'(seq_cmd.regs_on), 8'h01);
        check("oe_early", 8'(rst_oe), 8'h01);
        for (n = 0; n < 30 && rst_oe !== 1'b0; n++)
            @(negedge clk);
        check("oe_up", 8'(rst_oe), 8'h00);
        // Standby with hold-off code one: not before 32 slow ticks.
        hold_dly = 2'h1;
        stby_cmd = 1'b1;
        repeat (100) @(negedge clk);
        check("holdoff", 8'(power_state), 8'(ST_RUN));
        wait_st(ST_STANDBY, 400);
        check("down_req", 8'(seq_cmd.down_req), 8'h01);
        check("oe_stby", 8'(rst_oe), 8'h00);
        hold_dly = 2'h0;
        stby_cmd = 1'b0;
        wait_st(ST_RUN, 200);
        check("up_stby", 8'(seq_cmd.up_req), 8'h01);
        stby_inv = 1'b1;
        wait_st(ST_STANDBY, 200);
        // Sleep straight from standby, long debounce on the pin.
        dbnc_sel = 2'h3;
        pon = 1'b0;
        wait_st(ST_SLEEP, 200);
        check("down_slp", 8'(seq_cmd.down_req), 8'h01);
        stby_inv = 1'b0;
        pon = 1'b1;
        repeat (120) @(negedge clk);
        check("slp_hold", 8'(power_state), 8'(ST_SLEEP));
        wait_st(ST_RUN, 100);
        check("up_slp", 8'(seq_cmd.up_req), 8'h01);
        check("oe_slp", 8'(rst_oe), 8'h00);
        // Falling edge follows the mid selector, rising stays short.
        dbnc_sel = 2'h2;
        btn = 1'b0;
        repeat (16000) @(negedge clk);
        check("fall_early", 8'(button_int.fall), 8'h00);
        for (n = 0; n < 600 && button_int.fall !== 1'b1; n++)
            @(negedge clk);
        check("fall", 8'(button_int.fall), 8'h01);
        int_clr = 2'h2;
        @(negedge clk);
        int_clr = 2'h0;
        @(negedge clk);
        check("fall_clr", 8'(button_int.fall), 8'h00);
        btn = 1'b1;
        repeat (4000) @(negedge clk);
        check("rise_early", 8'(button_int.rise), 8'h00);
        for (n = 0; n < 400 && button_int.rise !== 1'b1; n++)
            @(negedge clk);
        check("rise", 8'(button_int.rise), 8'h01);
        // Turn-off with the flag set; thermal keeps the device off.
        dbnc_sel = 2'h0;
        therm = 1'b1;
        wait_st(ST_REGS_OFF, 20);
        repeat (2) @(negedge clk);
        check("oe_off", 8'(rst_oe), 8'h01);
        check("rise_off", 8'(button_int.rise), 8'h00);
        check("seq_off", 8'(seq_cmd), 8'h01);
        chg = 1'b1;
        core_req = 1'b1;
        repeat (20) @(negedge clk);
        check("core_chg", 8'(power_state), 8'(ST_REGS_OFF));
        chg = 1'b0;
        wait_st(ST_CORE_SHUT, 20);
        check("seq_core", 8'(seq_cmd), 8'h01);
        check("oe_core", 8'(rst_oe), 8'h01);
        core_req = 1'b0;
        chg = 1'b1;
        wait_st(ST_REGS_OFF, 40);
        chg = 1'b0;
        transport_state_req = 1'b1;
        wait_st(ST_TRANSPORT, 40);
        check("oe_transport_state", 8'(rst_oe), 8'h01);
        check("seq_transport_state", 8'(seq_cmd), 8'h00);
        transport_state_req = 1'b0;
        btn_rst_en = 1'b1;
        btn = 1'b0;
        wait_st(ST_REGS_OFF, 4800);
        // The same press, still held, counts again for core-shutdown.
        wait_st(ST_CORE_SHUT, 400);
        btn = 1'b1;
        btn_rst_en = 1'b0;
        // Second reset with the strap high: edge-sensitive power-on pin.
        therm = 1'b0;
        edge_cfg = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("edge_mode2", 8'(edge_mode), 8'h01);
        check("state2", 8'(power_state), 8'(ST_REGS_OFF));
        repeat (4200) @(negedge clk);
        check("edge_level", 8'(power_state), 8'(ST_REGS_OFF));
        lp_en = 1'b1;
        pon = 1'b0;
        wait_st(ST_RUN, 4400);
        wait_st(ST_SLEEP, 400);
        wait_st(ST_REGS_OFF, 400);
        test_done();
    end
endmodule
